// file: hw/scan_framer_pkg.sv
// Package with constants and carrier types of the scan packet body framer.
package scan_framer_pkg;

  // ---------------------------------------------------------------------
  // Pre-header constants
  // ---------------------------------------------------------------------
  localparam logic [7:0] SOP_FIRST = 8'hee;
  localparam logic [7:0] SOP_SECOND = 8'hff;
  localparam logic [7:0] VERSION_MAJOR = 8'h01;
  localparam logic [7:0] VERSION_MINOR = 8'h08;
  localparam logic [7:0] TYPE_CLOUD = 8'h00;
  localparam logic [7:0] TYPE_INERTIAL = 8'h01;
  localparam logic [7:0] RESERVED_BYTE = 8'h00;

  // ---------------------------------------------------------------------
  // Packet lengths in bytes, counted from the first pre-header byte
  // ---------------------------------------------------------------------
  localparam logic [6:0] CLOUD_LEN = 7'h4c;     // 76 covered and sent.
  localparam logic [6:0] INERTIAL_LEN = 7'h20;  // 32 covered, pad included.
  localparam logic [6:0] INERTIAL_SENT = 7'h1e; // 30 sent.
  localparam logic [6:0] CRC_LAST = 7'h03;      // Index of last CRC byte.

  // ---------------------------------------------------------------------
  // Checksum, side-data, sequence and FIFO constants
  // ---------------------------------------------------------------------
  localparam logic [31:0] CRC_POLY = 32'h04c11db7;
  localparam logic [31:0] CRC_INIT = 32'hffffffff;
  localparam logic [7:0] SLOT_FIRST = 8'h0c;
  localparam logic [7:0] SLOT_LAST = 8'h13;
  localparam logic [15:0] SEQ_RESET = 16'h0000;
  localparam int FIFO_DEPTH = 16;

  // ---------------------------------------------------------------------
  // Carrier types
  // ---------------------------------------------------------------------
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_BODY = 2'b01,
    ST_CRC = 2'b10
  } framer_state_t;

  typedef struct packed {
    logic [31:0] usec;
    logic [7:0] second;
    logic [7:0] minute;
    logic [7:0] hour;
    logic [7:0] day;
    logic [7:0] month;
    logic [7:0] year;
  } stamp_t;

  typedef struct packed {
    logic [15:0] azimuth;
    logic [15:0][15:0] range;
    logic [15:0][7:0] reflect;
    logic [15:0][1:0] contam;
  } cloud_sample_t;

  typedef struct packed {
    logic [15:0] gyro_z;
    logic [15:0] gyro_y;
    logic [15:0] gyro_x;
    logic [15:0] accel_z;
    logic [15:0] accel_y;
    logic [15:0] accel_x;
  } inertial_sample_t;

  typedef struct packed {
    logic last;
    logic [7:0] data;
  } stream_beat_t;

endpackage

// file: hw/beat_fifo.sv
// Flip-flop FIFO with valid and ready on both sides.
`timescale 1ns/1ns
module beat_fifo #(
  parameter int WIDTH = 9,
  parameter int DEPTH = 16
) (
  // Clock and reset.
  input wire logic clock_i,
  input wire logic nrst_i,
  // Filling side.
  input wire logic in_valid_i,
  input wire logic [WIDTH-1:0] in_data_i,
  output logic in_ready_o,
  // Draining side.
  output logic out_valid_o,
  output logic [WIDTH-1:0] out_data_o,
  input wire logic out_ready_i
);

  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0] wr_ptr;
  logic [AW:0] rd_ptr;
  wire logic full = (wr_ptr[AW] != rd_ptr[AW]) &&
                    (wr_ptr[AW-1:0] == rd_ptr[AW-1:0]);
  wire logic empty = (wr_ptr == rd_ptr);
  wire logic push = in_valid_i && !full;
  wire logic pop = out_ready_i && !empty;

  // Handshakes follow the fill level directly.
  assign in_ready_o = !full;
  assign out_valid_o = !empty;
  assign out_data_o = mem[rd_ptr[AW-1:0]];

  // Storage is written only, it needs no reset.
  always_ff @(posedge clock_i) begin
    if (push) begin
      mem[wr_ptr[AW-1:0]] <= in_data_i;
    end
  end

  // Pointers carry one extra bit to tell full from empty.
  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
    end else begin
      if (push) begin
        wr_ptr <= wr_ptr + 1'b1;
      end
      if (pop) begin
        rd_ptr <= rd_ptr + 1'b1;
      end
    end
  end

endmodule // beat_fifo

// file: hw/scan_packet_body_framer.sv
// Framer that builds whole point cloud and inertial packets as bytes.
`timescale 1ns/1ns

module scan_packet_body_framer (
  // Clock and reset.
  input wire logic clock_i,
  input wire logic nrst_i,
  // Packet request, taken while idle.
  input wire logic req_valid_i,
  input wire logic req_inertial_i,
  output logic req_ready_o,
  // Packet contents, sampled when the request is taken.
  input wire scan_framer_pkg::stamp_t stamp_i,
  input wire scan_framer_pkg::cloud_sample_t cloud_i,
  input wire scan_framer_pkg::inertial_sample_t inertial_i,
  input wire logic [63:0] sw_version_i,
  input wire logic [63:0] fw_version_i,
  // Outgoing byte stream.
  output logic out_valid_o,
  output scan_framer_pkg::stream_beat_t out_beat_o,
  input wire logic out_ready_i,
  // Status.
  output logic busy_o,
  output logic [15:0] cloud_packet_seq_o,
  output logic [15:0] inertial_packet_seq_o
);

  // -----------------------------------------------------------------------
  // Checksum step
  // -----------------------------------------------------------------------

  // Advances a CRC-32/MPEG-2 state by one byte, most significant bit first.
  function automatic logic [31:0] crc_step(input logic [31:0] crc,
                                           input logic [7:0] data);
    logic [31:0] c;
    c = crc ^ {data, 24'h000000};
    for (int i = 0; i < 8; i++) begin
      c = c[31] ? ((c << 1) ^ scan_framer_pkg::CRC_POLY) : (c << 1);
    end
    return c;
  endfunction

  // -----------------------------------------------------------------------
  // State
  // -----------------------------------------------------------------------
  scan_framer_pkg::framer_state_t state;
  logic inertial;
  scan_framer_pkg::stamp_t stamp;
  scan_framer_pkg::cloud_sample_t cloud;
  scan_framer_pkg::inertial_sample_t imu;
  logic [63:0] sw_version;
  logic [63:0] fw_version;
  logic [6:0] idx;
  logic [31:0] crc;
  logic [15:0] cloud_packet_seq;
  logic [15:0] inertial_packet_seq;
  logic [7:0] side_slot_index;

  // FIFO filling side.
  logic fifo_in_ready;
  logic fifo_in_valid;
  scan_framer_pkg::stream_beat_t fifo_in_beat;

  // -----------------------------------------------------------------------
  // Packet images, byte 0 in the lowest bits
  // -----------------------------------------------------------------------

  // Pre-header: start bytes, structure version, reserved and type.
  wire logic [7:0] type_byte = inertial ? scan_framer_pkg::TYPE_INERTIAL
                                        : scan_framer_pkg::TYPE_CLOUD;
  wire logic [47:0] pre_flat = {type_byte,
                                scan_framer_pkg::RESERVED_BYTE,
                                scan_framer_pkg::VERSION_MINOR,
                                scan_framer_pkg::VERSION_MAJOR,
                                scan_framer_pkg::SOP_SECOND,
                                scan_framer_pkg::SOP_FIRST};

  // Header: date bytes year first, then the microsecond stamp.
  wire logic [79:0] stamp_flat = {stamp.usec, stamp.second, stamp.minute,
                                  stamp.hour, stamp.day, stamp.month,
                                  stamp.year};

  // Measurement block, one three-byte entry per channel.
  logic [383:0] block_flat;
  for (genvar ch = 0; ch < 16; ch++) begin : g_entry
    // Range in 4 mm steps, then reflectance in 1 percent steps.
    assign block_flat[ch*24 +: 24] = {cloud.reflect[ch],
                                      cloud.range[ch]};
  end

  // Side data: version pair chosen by the low bits of the slot index.
  wire logic slot_is_fw = side_slot_index[4];
  wire logic [1:0] slot_pair = ~side_slot_index[1:0];
  wire logic [63:0] version_sel = slot_is_fw ? fw_version
                                             : sw_version;
  wire logic [63:0] version_shift = version_sel << {slot_pair, 4'h0};
  wire logic [15:0] side_data = {version_shift[55:48],
                                 version_shift[63:56]};

  // Whole covered cloud packet, 76 bytes.
  wire logic [607:0] cloud_flat = {cloud_packet_seq,
                                   side_data,
                                   side_slot_index,
                                   scan_framer_pkg::RESERVED_BYTE,
                                   cloud.contam,
                                   block_flat,
                                   cloud.azimuth,
                                   stamp_flat,
                                   pre_flat};

  // Whole covered inertial packet, 30 bytes and two zero pad bytes.
  wire logic [255:0] imu_flat = {16'h0000,
                                 inertial_packet_seq,
                                 imu.gyro_z, imu.gyro_y,
                                 imu.gyro_x,
                                 imu.accel_z, imu.accel_y,
                                 imu.accel_x,
                                 stamp_flat,
                                 pre_flat};

  // -----------------------------------------------------------------------
  // Byte selection and stepping
  // -----------------------------------------------------------------------

  // Current covered byte, index bounded by the packet kind.
  wire logic [7:0] cloud_byte = cloud_flat[{idx, 3'b000} +: 8];
  wire logic [7:0] imu_byte = imu_flat[{idx[4:0], 3'b000} +: 8];
  wire logic [7:0] cur_byte = inertial ? imu_byte : cloud_byte;

  // Lengths of the covered range and of the bytes that go out.
  wire logic [6:0] cover_len = inertial ? scan_framer_pkg::INERTIAL_LEN
                                        : scan_framer_pkg::CLOUD_LEN;
  wire logic [6:0] sent_len = inertial ? scan_framer_pkg::INERTIAL_SENT
                                       : scan_framer_pkg::CLOUD_LEN;

  // Pad bytes feed the checksum but never reach the stream.
  wire logic in_body = (state == scan_framer_pkg::ST_BODY);
  wire logic in_crc = (state == scan_framer_pkg::ST_CRC);
  wire logic is_pad = in_body && (idx >= sent_len);
  wire logic body_step = in_body && (is_pad || fifo_in_ready);
  wire logic body_done = body_step && (idx == cover_len - 7'h01);
  wire logic crc_step_ok = in_crc && fifo_in_ready;
  wire logic crc_done = crc_step_ok && (idx == scan_framer_pkg::CRC_LAST);
  wire logic take_req = (state == scan_framer_pkg::ST_IDLE) && req_valid_i;

  // Checksum bytes leave least significant first.
  wire logic [7:0] crc_byte = crc[{idx[1:0], 3'b000} +: 8];

  // Beat towards the FIFO; the last checksum byte closes the packet.
  assign fifo_in_valid = (in_body && !is_pad) || in_crc;
  assign fifo_in_beat.data = in_crc ? crc_byte : cur_byte;
  assign fifo_in_beat.last = crc_done;

  // Status outputs.
  assign req_ready_o = (state == scan_framer_pkg::ST_IDLE);
  assign busy_o = !req_ready_o;
  assign cloud_packet_seq_o = cloud_packet_seq;
  assign inertial_packet_seq_o = inertial_packet_seq;

  // -----------------------------------------------------------------------
  // Sequencer
  // -----------------------------------------------------------------------

  // Walks idle, covered bytes and checksum bytes.
  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      state <= scan_framer_pkg::ST_IDLE;
      idx <= '0;
    end else begin
      case (state)
        scan_framer_pkg::ST_IDLE: begin
          if (take_req) begin
            state <= scan_framer_pkg::ST_BODY;
            idx <= '0;
          end
        end
        scan_framer_pkg::ST_BODY: begin
          if (body_done) begin
            state <= scan_framer_pkg::ST_CRC;
            idx <= '0;
          end else if (body_step) begin
            idx <= idx + 7'h01;
          end
        end
        scan_framer_pkg::ST_CRC: begin
          if (crc_done) begin
            state <= scan_framer_pkg::ST_IDLE;
            idx <= '0;
          end else if (crc_step_ok) begin
            idx <= idx + 7'h01;
          end
        end
        default: begin
          state <= scan_framer_pkg::ST_IDLE;
          idx <= '0;
        end
      endcase
    end
  end

  // Checksum runs over every covered byte, pad bytes included.
  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      crc <= scan_framer_pkg::CRC_INIT;
    end else if (take_req) begin
      crc <= scan_framer_pkg::CRC_INIT;
    end else if (body_step) begin
      crc <= crc_step(crc, cur_byte);
    end
  end

  // Packet contents are frozen for the whole packet.
  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      inertial <= 1'b0;
      stamp <= '0;
      cloud <= '0;
      imu <= '0;
      sw_version <= '0;
      fw_version <= '0;
    end else if (take_req) begin
      inertial <= req_inertial_i;
      stamp <= stamp_i;
      cloud <= cloud_i;
      imu <= inertial_i;
      sw_version <= sw_version_i;
      fw_version <= fw_version_i;
    end
  end

  // Sequence numbers advance once a packet's last byte is queued.
  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      cloud_packet_seq <= scan_framer_pkg::SEQ_RESET;
      inertial_packet_seq <= scan_framer_pkg::SEQ_RESET;
    end else if (crc_done) begin
      if (inertial) begin
        inertial_packet_seq <= inertial_packet_seq + 16'h0001;
      end else begin
        cloud_packet_seq <= cloud_packet_seq + 16'h0001;
      end
    end
  end

  // Slot index cycles through both version ranges, one per cloud packet.
  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      side_slot_index <= scan_framer_pkg::SLOT_FIRST;
    end else if (crc_done && !inertial) begin
      if (side_slot_index == scan_framer_pkg::SLOT_LAST) begin
        side_slot_index <= scan_framer_pkg::SLOT_FIRST;
      end else begin
        side_slot_index <= side_slot_index + 8'h01;
      end
    end
  end

  // -----------------------------------------------------------------------
  // Output buffer
  // -----------------------------------------------------------------------

  // Back-pressure from the stream stalls the sequencer through the FIFO.
  beat_fifo #(
    .WIDTH($bits(scan_framer_pkg::stream_beat_t)),
    .DEPTH(scan_framer_pkg::FIFO_DEPTH)
  ) u_fifo (
    .clock_i(clock_i),
    .nrst_i(nrst_i),
    .in_valid_i(fifo_in_valid),
    .in_data_i(fifo_in_beat),
    .in_ready_o(fifo_in_ready),
    .out_valid_o(out_valid_o),
    .out_data_o(out_beat_o),
    .out_ready_i(out_ready_i)
  );

endmodule // scan_packet_body_framer

// file: sim/scan_framer_properties.sv
// Concurrent checks on the framer's request and byte stream ports.
`timescale 1ns/1ns
module scan_framer_properties (
  // Clock and reset.
  input wire logic clock_i,
  input wire logic nrst_i,
  // Request and stream.
  input wire logic req_valid_i,
  input wire logic req_ready_o,
  input wire logic out_valid_o,
  input wire scan_framer_pkg::stream_beat_t out_beat_o,
  input wire logic out_ready_i,
  // Sequence numbers.
  input wire logic [15:0] cloud_packet_seq_o,
  input wire logic [15:0] inertial_packet_seq_o
);
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!nrst_i);
  logic [6:0] pos;
  wire acc = out_valid_o && out_ready_i;
  wire [7:0] dat = out_beat_o.data;
  // Counts accepted bytes inside the packet now on the wire.
  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) pos <= 7'h00;
    else if (acc) pos <= out_beat_o.last ? 7'h00 : pos + 7'h01;
  end
  property p_first_byte;
    req_valid_i && req_ready_o && !out_valid_o |-> ##2
      out_valid_o && dat == scan_framer_pkg::SOP_FIRST;
  endproperty
  a_first_byte: assert property (p_first_byte)
    else $error("First packet byte late or wrong.");
  property p_hold;
    out_valid_o && !out_ready_i |=> out_valid_o && $stable(out_beat_o);
  endproperty
  a_hold: assert property (p_hold)
    else $error("Stalled byte changed.");
  property p_length;
    acc && out_beat_o.last |-> pos == 7'd79 || pos == 7'd33;
  endproperty
  a_length: assert property (p_length)
    else $error("Packet length wrong.");
  property p_sop;
    acc && pos == 7'd0 |-> dat == scan_framer_pkg::SOP_FIRST;
  endproperty
  a_sop: assert property (p_sop)
    else $error("Packet start byte wrong.");
  property p_major;
    acc && pos == 7'd2 |-> dat == 8'h01;
  endproperty
  a_major: assert property (p_major)
    else $error("Major version byte wrong.");
  property p_minor;
    acc && pos == 7'd3 |-> dat == 8'h08;
  endproperty
  a_minor: assert property (p_minor)
    else $error("Minor version byte wrong.");
  property p_type;
    acc && pos == 7'd5 |-> dat == 8'h00 || dat == 8'h01;
  endproperty
  a_type: assert property (p_type)
    else $error("Packet type byte wrong.");
  property p_seq_step;
    $changed(cloud_packet_seq_o) |->
      cloud_packet_seq_o == $past(cloud_packet_seq_o) + 16'h0001;
  endproperty
  a_seq_step: assert property (p_seq_step)
    else $error("Cloud sequence did not step by one.");
  property p_seq_apart;
    $changed(inertial_packet_seq_o) |-> $stable(cloud_packet_seq_o);
  endproperty
  a_seq_apart: assert property (p_seq_apart)
    else $error("Sequence counters moved together.");
endmodule // scan_framer_properties

bind scan_packet_body_framer scan_framer_properties u_props (
  .clock_i(clock_i), .nrst_i(nrst_i), .req_valid_i(req_valid_i),
  .req_ready_o(req_ready_o), .out_valid_o(out_valid_o),
  .out_beat_o(out_beat_o), .out_ready_i(out_ready_i),
  .cloud_packet_seq_o(cloud_packet_seq_o),
  .inertial_packet_seq_o(inertial_packet_seq_o)
);

// file: sim/host_stream_sink.sv
// Host receiver model that collects bytes and checks each packet's CRC.
`timescale 1ns/1ns
module host_stream_sink (
  // Clock and reset.
  input wire logic clock_i,
  input wire logic nrst_i,
  // Byte stream from the framer.
  input wire logic valid_i,
  input wire scan_framer_pkg::stream_beat_t beat_i,
  output logic ready_o,
  // Pacing controls.
  input wire logic stall_i,
  input wire logic slow_i
);
  scan_framer_pkg::stream_beat_t got[$];
  logic [7:0] pkt[$];
  logic [31:0] rx;
  logic phase;
  int crc_bad = 0;
  logic [15:0] block_angle = 16'h0000;
  // Horizontal angle in 0.01 degree steps, zero on Y, clockwise positive.
  function automatic int horiz_angle(input int offset);
    return (int'(block_angle) + offset) % 36000;
  endfunction
  // Elevation sign: zero is horizontal, upwards is positive.
  function automatic int elev_sign(input int elev);
    return (elev > 0) ? 1 : ((elev < 0) ? -1 : 0);
  endfunction
  // Bitwise CRC, most significant bit first, no reflection or final xor.
  function automatic logic [31:0] crc32(input logic [7:0] q[$]);
    logic [31:0] c;
    c = 32'hffffffff;
    foreach (q[i]) begin
      c ^= {q[i], 24'h000000};
      for (int b = 0; b < 8; b++) c = c[31] ? (c << 1) ^ 32'h04c11db7 : c << 1;
    end
    return c;
  endfunction
  // Ready changes just after an edge; slow mode halves the byte rate.
  always @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      ready_o <= 1'b0;
      phase <= 1'b0;
    end else begin
      phase <= !phase;
      ready_o <= !stall_i && !(slow_i && phase);
    end
  end
  // Stores accepted bytes and checks the CRC, zero padded to whole words.
  always @(posedge clock_i) begin
    if (!nrst_i) begin
      pkt.delete();
    end else if (valid_i && ready_o) begin
      got.push_back(beat_i);
      pkt.push_back(beat_i.data);
      if (beat_i.last) begin
        rx = {pkt[$], pkt[$-1], pkt[$-2], pkt[$-3]};
        repeat (4) void'(pkt.pop_back());
        if (pkt.size() == 76) block_angle = {pkt[17], pkt[16]};
        if (pkt.size() % 4 != 0) pkt = {pkt, 8'h00, 8'h00};
        if (crc32(pkt) != rx) crc_bad++;
        pkt.delete();
      end
    end
  end
endmodule // host_stream_sink

// file: sim/scan_packet_body_framer_bench.sv
// Self-checking bench of the scan packet body framer.
`timescale 1ns/1ns
module scan_packet_body_framer_bench;
  logic clock_i = 1'b0;
  logic nrst_i = 1'b0;
  logic req_valid_i = 1'b0;
  logic req_inertial_i = 1'b0;
  logic stall_i = 1'b0;
  logic slow_i = 1'b0;
  logic req_ready_o, out_valid_o, out_ready, busy_o;
  logic [15:0] cloud_packet_seq_o, inertial_packet_seq_o;
  scan_framer_pkg::stream_beat_t out_beat_o;
  scan_framer_pkg::stamp_t stamp;
  scan_framer_pkg::cloud_sample_t cloud;
  scan_framer_pkg::inertial_sample_t imu;
  logic [63:0] sw = "00.07.6 ";
  logic [63:0] fw = "1.2.3-rc";
  logic [7:0] exp[$];
  logic [15:0] cseq = 16'h0000;
  logic [15:0] iseq = 16'h0000;
  logic [7:0] slot = 8'h0c;
  int err_total = 0;
  int n_tests = 0;
  // Free running 100 MHz clock.
  always #5 clock_i = ~clock_i;
  scan_packet_body_framer DUT (.clock_i(clock_i), .nrst_i(nrst_i),
    .req_valid_i(req_valid_i), .req_inertial_i(req_inertial_i),
    .req_ready_o(req_ready_o), .stamp_i(stamp), .cloud_i(cloud),
    .inertial_i(imu), .sw_version_i(sw), .fw_version_i(fw),
    .out_valid_o(out_valid_o), .out_beat_o(out_beat_o),
    .out_ready_i(out_ready), .busy_o(busy_o),
    .cloud_packet_seq_o(cloud_packet_seq_o),
    .inertial_packet_seq_o(inertial_packet_seq_o));
  host_stream_sink HOST (.clock_i(clock_i), .nrst_i(nrst_i),
    .valid_i(out_valid_o), .beat_i(out_beat_o), .ready_o(out_ready),
    .stall_i(stall_i), .slow_i(slow_i));
  task automatic summarize;
    $display("Comparisons %0d, mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] want);
    n_tests++;
    if (seen !== want) begin
      err_total++;
      $display("MISMATCH t=%0t seen=%h want=%h", $time, seen, want);
    end
  endtask
  task automatic push16(input logic [15:0] v);
    exp.push_back(v[7:0]);
    exp.push_back(v[15:8]);
  endtask
  // Builds the whole expected packet, least significant byte first.
  task automatic build(input logic kind);
    logic [7:0] cov[$];
    logic [63:0] v;
    logic [31:0] c;
    int p;
    exp = {scan_framer_pkg::SOP_FIRST, scan_framer_pkg::SOP_SECOND, 8'h01,
      8'h08, 8'h00, 8'(kind), stamp.year, stamp.month, stamp.day,
      stamp.hour, stamp.minute, stamp.second};
    push16(stamp.usec[15:0]);
    push16(stamp.usec[31:16]);
    if (kind) begin
      push16(imu.accel_x);
      push16(imu.accel_y);
      push16(imu.accel_z);
      push16(imu.gyro_x);
      push16(imu.gyro_y);
      push16(imu.gyro_z);
      push16(iseq);
    end else begin
      push16(cloud.azimuth);
      for (int i = 0; i < 16; i++) begin
        push16(cloud.range[i]);
        exp.push_back(cloud.reflect[i]);
      end
      push16(cloud.contam[7:0]);
      push16(cloud.contam[15:8]);
      v = (slot <= 8'h0f) ? sw : fw;
      p = (slot <= 8'h0f) ? 15 - slot : 19 - slot;
      exp.push_back(8'h00);
      exp.push_back(slot);
      exp.push_back(v[63 - 16 * p -: 8]);
      exp.push_back(v[55 - 16 * p -: 8]);
      push16(cseq);
    end
    cov = exp;
    if (kind) cov = {cov, 8'h00, 8'h00};
    c = HOST.crc32(cov);
    push16(c[15:0]);
    push16(c[31:16]);
  endtask
  // Requests one packet, optionally stalls the host, and compares it.
  task automatic run_packet(input logic kind, input logic slow, input int st);
    int n;
    build(kind);
    HOST.got.delete();
    stall_i = (st > 0);
    slow_i = slow;
    n = 0;
    while (req_ready_o !== 1'b1 && n < 200) begin
      @(negedge clock_i);
      n++;
    end
    req_valid_i = 1'b1;
    req_inertial_i = kind;
    @(negedge clock_i);
    req_valid_i = 1'b0;
    repeat (st) @(negedge clock_i);
    if (st > 0) check(busy_o, 1'b1);
    stall_i = 1'b0;
    n = 0;
    while (HOST.got.size() < exp.size() && n < 3000) begin
      @(negedge clock_i);
      n++;
    end
    check(HOST.got.size(), exp.size());
    foreach (exp[i]) begin
      check(HOST.got[i].data, exp[i]);
      check(HOST.got[i].last, i == exp.size() - 1);
    end
    if (kind) begin
      iseq++;
    end else begin
      cseq++;
      slot = (slot == 8'h13) ? 8'h0c : slot + 8'h01;
    end
    check(cloud_packet_seq_o, cseq);
    check(inertial_packet_seq_o, iseq);
    check(HOST.crc_bad, 0);
  endtask
  task automatic scn_cloud;
    run_packet(1'b0, 1'b0, 0);
    check({HOST.got[17].data, HOST.got[16].data}, 16'h8c9f);
    check({HOST.got[64].data, HOST.got[63].data}, 16'h1fff);
    check(HOST.got[20].data, 8'h00);
    check(HOST.got[65].data, 8'hff);
    check(HOST.got[66].data, 8'he4);
    check(HOST.horiz_angle(500), 499);
    check(HOST.elev_sign(1064), 1);
    check(HOST.got[71].data, 8'h0c);
  endtask
  task automatic scn_imu;
    run_packet(1'b1, 1'b0, 40);
    check({HOST.got[17].data, HOST.got[16].data}, 16'he000);
    check({HOST.got[23].data, HOST.got[22].data}, 16'h0123);
  endtask
  task automatic scn_slots;
    for (int k = 0; k < 8; k++) begin
      run_packet(1'b0, k[0], 0);
      check(HOST.got[71].data, 8'h0d + 8'(k) - (k == 7 ? 8'h08 : 8'h00));
    end
  endtask
  task automatic scn_reset;
    req_valid_i = 1'b1;
    @(negedge clock_i);
    req_valid_i = 1'b0;
    repeat (20) @(negedge clock_i);
    nrst_i = 1'b0;
    @(negedge clock_i);
    check(req_ready_o, 1'b1);
    check(out_valid_o, 1'b0);
    check(cloud_packet_seq_o, 16'h0000);
    check(inertial_packet_seq_o, 16'h0000);
    nrst_i = 1'b1;
    cseq = 16'h0000;
    iseq = 16'h0000;
    slot = 8'h0c;
    @(negedge clock_i);
    run_packet(1'b0, 1'b0, 0);
    check(HOST.got[71].data, 8'h0c);
  endtask
  // Cuts a hung run short.
  initial begin
    #200000;
    err_total++;
    summarize();
  end
  // Sets inputs, resets for 12 cycles, then runs the scenarios.
  initial begin
    stamp = {32'h000f423f, 8'h3b, 8'h3b, 8'h17, 8'h1f, 8'h0c, 8'h7d};
    cloud.azimuth = 16'h8c9f;
    for (int i = 0; i < 16; i++) begin
      cloud.range[i] = 16'h1000 + 16'(16'h0111 * i);
      cloud.reflect[i] = 8'(17 * i);
      cloud.contam[i] = 2'(i);
    end
    imu = {16'h7fff, 16'h8000, 16'h0123, 16'hfff8, 16'h2000, 16'he000};
    repeat (12) @(posedge clock_i);
    @(negedge clock_i);
    nrst_i = 1'b1;
    check(req_ready_o, 1'b1);
    check(cloud_packet_seq_o, 16'h0000);
    scn_cloud();
    scn_imu();
    scn_slots();
    scn_reset();
    summarize();
  end
endmodule // scan_packet_body_framer_bench
